/* File: inc/emf_regs.svh */
// Constants of the escaped message framer
// How it works
// - Each frame opens with one marker byte 0x02, and any 0x02 starts a frame except one behind an escape prefix inside a frame.
// - Each frame closes with one marker byte 0x03, which follows the four check-word bytes.
// - The escape prefix byte is 0x1B on both directions.
// - The check word is a 32-bit CRC of four bytes over the original bytes only, not the markers.
// - The sender replaces every 0x02, 0x03 or 0x1B in body and check word by 0x1B and that byte.
// - The sender computes and appends the check word, then escapes, then adds the markers.
// - No bare open or close marker appears between the markers of a frame.
// - Inside a frame the receiver drops each escape prefix and keeps the next byte as data, never as a marker.
// - The receiver checks the check word only over the bytes left after escapes are removed.
// - The receiver uses the unescaped markers to find frame start, check word and frame end.
// - Bytes travel as raw binary, the same whether on a serial line or in video.
`ifndef EMF_REGS_SVH
`define EMF_REGS_SVH
`define EMF_SOF 8'h02
`define EMF_EOF 8'h03
`define EMF_ESC 8'h1B
`define EMF_POLY 32'h04C11DB7
`define EMF_CRC_INIT 32'hFFFFFFFF
`define EMF_CRC_BYTES 3'h4
`define EMF_CRC_LAST 2'h3
`endif

/* File: inc/emf_pkg.sv */
// Types of the escaped message framer
package emf_pkg;
  typedef enum logic [2:0] {
    EMF_TX_IDLE = 3'b000,
    EMF_TX_SOF = 3'b001,
    EMF_TX_BODY = 3'b010,
    EMF_TX_CRC = 3'b011,
    EMF_TX_EOF = 3'b100
  } emf_tx_e;
endpackage

/* File: rtl/emf_crc.sv */
// Byte-wide CRC-32 update step
`timescale 1ns/1ps
`include "emf_regs.svh"
module emf_crc (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);
  // MSB first, non-reflected
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[31] ^ data[i]) begin
        c = {c[30:0], 1'b0} ^ `EMF_POLY;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule

/* File: rtl/emf_framer.sv */
// Escaped message framer and deframer
`timescale 1ns/1ps
`include "emf_regs.svh"
module emf_framer (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  output logic [7:0] line_tx_data,
  output logic line_tx_valid,
  input wire logic line_tx_ready,
  input wire logic [7:0] line_rx_data,
  input wire logic line_rx_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_good,
  output logic rx_error
);
  // ****************************************
  // Transmit side
  // ****************************************
  function automatic logic is_reserved(input logic [7:0] b);
    is_reserved = (b == `EMF_SOF) || (b == `EMF_EOF) || (b == `EMF_ESC);
  endfunction

  emf_pkg::emf_tx_e tx_st_q;
  logic [31:0] tx_crc_q;
  logic [31:0] tx_crc_d;
  logic [7:0] tx_hold_q;
  logic tx_esc_q;
  logic tx_last_q;
  logic [1:0] tx_idx_q;
  logic tx_busy_q;
  logic [7:0] tx_crc_byte;
  logic line_free;
  logic tx_take;

  emf_crc u_tx_crc (
    .crc_in(tx_crc_q),
    .data(tx_data),
    .crc_out(tx_crc_d)
  );

  assign line_free = !line_tx_valid || line_tx_ready;
  assign tx_crc_byte = tx_crc_q[31:24];
  assign tx_take = tx_valid && tx_ready;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q <= emf_pkg::EMF_TX_IDLE;
      tx_crc_q <= `EMF_CRC_INIT;
      tx_hold_q <= 8'h00;
      tx_esc_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_idx_q <= 2'h0;
      tx_busy_q <= 1'b0;
      tx_ready <= 1'b0;
      line_tx_data <= 8'h00;
      line_tx_valid <= 1'b0;
    end else begin
      if (line_tx_valid && line_tx_ready) begin
        line_tx_valid <= 1'b0;
      end
      tx_ready <= 1'b0;
      unique case (tx_st_q)
        emf_pkg::EMF_TX_IDLE: begin
          if (tx_valid) begin
            tx_st_q <= emf_pkg::EMF_TX_SOF;
          end
        end
        emf_pkg::EMF_TX_SOF: begin
          if (line_free) begin
            line_tx_data <= `EMF_SOF;
            line_tx_valid <= 1'b1;
            tx_crc_q <= `EMF_CRC_INIT;
            tx_busy_q <= 1'b0;
            tx_st_q <= emf_pkg::EMF_TX_BODY;
          end
        end
        emf_pkg::EMF_TX_BODY: begin
          if (tx_take) begin
            tx_crc_q <= tx_crc_d;
            tx_hold_q <= tx_data;
            tx_esc_q <= is_reserved(tx_data);
            tx_last_q <= tx_last;
            tx_busy_q <= 1'b1;
          end else if (tx_busy_q && line_free) begin
            line_tx_valid <= 1'b1;
            if (tx_esc_q) begin
              line_tx_data <= `EMF_ESC;
              tx_esc_q <= 1'b0;
            end else begin
              line_tx_data <= tx_hold_q;
              tx_busy_q <= 1'b0;
              if (tx_last_q) begin
                tx_st_q <= emf_pkg::EMF_TX_CRC;
                tx_idx_q <= 2'h0;
              end
            end
          end else if (!tx_busy_q && !tx_ready) begin
            tx_ready <= 1'b1;
          end
        end
        emf_pkg::EMF_TX_CRC: begin
          if (line_free) begin
            line_tx_valid <= 1'b1;
            if (is_reserved(tx_crc_byte) && !tx_esc_q) begin
              line_tx_data <= `EMF_ESC;
              tx_esc_q <= 1'b1;
            end else begin
              line_tx_data <= tx_crc_byte;
              tx_esc_q <= 1'b0;
              tx_crc_q <= {tx_crc_q[23:0], 8'h00};
              tx_idx_q <= tx_idx_q + 2'h1;
              if (tx_idx_q == `EMF_CRC_LAST) begin
                tx_st_q <= emf_pkg::EMF_TX_EOF;
              end
            end
          end
        end
        emf_pkg::EMF_TX_EOF: begin
          if (line_free) begin
            line_tx_data <= `EMF_EOF;
            line_tx_valid <= 1'b1;
            tx_st_q <= emf_pkg::EMF_TX_IDLE;
          end
        end
        default: begin
          tx_st_q <= emf_pkg::EMF_TX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Receive side
  // ****************************************
  logic rx_in_q;
  logic rx_esc_q;
  logic [31:0] rx_crc_q;
  logic [31:0] rx_crc_d;
  logic [7:0] rx_byte;
  logic rx_data_in;
  logic [2:0] rx_cnt_q;

  assign rx_byte = line_rx_data;
  assign rx_data_in = line_rx_valid && rx_in_q &&
                      (rx_esc_q || ((rx_byte != `EMF_ESC) && (rx_byte != `EMF_SOF) &&
                                    (rx_byte != `EMF_EOF)));

  emf_crc u_rx_crc (
    .crc_in(rx_crc_q),
    .data(rx_byte),
    .crc_out(rx_crc_d)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_in_q <= 1'b0;
      rx_esc_q <= 1'b0;
      rx_crc_q <= `EMF_CRC_INIT;
      rx_cnt_q <= 3'h0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_good <= 1'b0;
      rx_error <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_good <= 1'b0;
      rx_error <= 1'b0;
      if (line_rx_valid) begin
        if (rx_esc_q) begin
          rx_esc_q <= 1'b0;
        end else if (rx_byte == `EMF_ESC) begin
          rx_esc_q <= rx_in_q;
        end else if (rx_byte == `EMF_SOF) begin
          rx_error <= rx_in_q;
          rx_in_q <= 1'b1;
          rx_sof <= 1'b1;
          rx_crc_q <= `EMF_CRC_INIT;
          rx_cnt_q <= 3'h0;
        end else if (rx_byte == `EMF_EOF && rx_in_q) begin
          rx_in_q <= 1'b0;
          if (rx_cnt_q == `EMF_CRC_BYTES && rx_crc_q == 32'h00000000) begin
            rx_good <= 1'b1;
          end else begin
            rx_error <= 1'b1;
          end
        end
        if (rx_data_in) begin
          rx_crc_q <= rx_crc_d;
          rx_data <= rx_byte;
          rx_valid <= 1'b1;
          if (rx_cnt_q != `EMF_CRC_BYTES) begin
            rx_cnt_q <= rx_cnt_q + 3'h1;
          end
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Next line byte is the literal behind an escape prefix
  logic tx_lit_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_lit_q <= 1'b0;
    end else if (line_tx_valid && line_tx_ready) begin
      tx_lit_q <= !tx_lit_q && (line_tx_data == `EMF_ESC);
    end
  end

  sof_first_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (tx_st_q == emf_pkg::EMF_TX_SOF && line_free) |=> line_tx_data == `EMF_SOF)
    else $error("open marker not sent");
  eof_last_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (tx_st_q == emf_pkg::EMF_TX_EOF && line_free) |=>
    (line_tx_data == `EMF_EOF && tx_st_q == emf_pkg::EMF_TX_IDLE))
    else $error("close marker not sent");
  esc_pair_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (line_tx_valid && line_tx_ready && !tx_lit_q && line_tx_data == `EMF_ESC) |=>
    (line_tx_valid && is_reserved(line_tx_data)))
    else $error("escape not followed by reserved byte");
  lit_reserved_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (line_tx_valid && line_tx_ready && tx_lit_q) |-> is_reserved(line_tx_data))
    else $error("escape prefix before plain byte");
  crc_after_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (tx_st_q == emf_pkg::EMF_TX_CRC) |-> (tx_last_q && !tx_busy_q))
    else $error("check word without body");
  rx_esc_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_esc_q && line_rx_valid) |=> (rx_valid && !rx_sof && rx_data == $past(line_rx_data)))
    else $error("escaped byte lost");
  rx_sof_sync_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (line_rx_valid && !rx_esc_q && line_rx_data == `EMF_SOF) |=> (rx_sof && rx_in_q))
    else $error("open marker not taken");
  rx_abort_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (line_rx_valid && !rx_esc_q && rx_in_q && line_rx_data == `EMF_SOF) |=> rx_error)
    else $error("mid-frame open not flagged");
  rx_check_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rx_good |-> ($past(rx_crc_q) == 32'h00000000 && !rx_error))
    else $error("good frame with bad check");
  tx_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (line_tx_valid && !line_tx_ready) |=> (line_tx_valid && $stable(line_tx_data)))
    else $error("line byte dropped under stall");
  good_frame_c: cover property (@(posedge mclk) disable iff (!rst_b) rx_good);
  bad_frame_c: cover property (@(posedge mclk) disable iff (!rst_b) rx_error);
  tx_escape_c: cover property (@(posedge mclk) disable iff (!rst_b)
    tx_st_q == emf_pkg::EMF_TX_CRC && tx_esc_q);
endmodule

/* File: sim/emf_line_model.sv */
// Line partner that takes framer bytes, promptly or slowly
`timescale 1ns/1ps
module emf_line_model (
  input wire logic mclk,
  input wire logic [7:0] line_tx_data,
  input wire logic line_tx_valid,
  output logic line_tx_ready,
  input wire logic slow
);
  logic [7:0] seen [$];
  logic [1:0] ph_q;
  initial ph_q = 2'h0;
  // Slow mode accepts one byte in four cycles
  assign line_tx_ready = !slow || (ph_q == 2'h3);
  always @(posedge mclk) begin
    ph_q <= ph_q + 2'h1;
    if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1) begin
      seen.push_back(line_tx_data);
    end
  end
endmodule

/* File: sim/emf_framer_tb_top.sv */
// Testbench of the escaped message framer
`timescale 1ns/1ps
module emf_framer_tb_top;
  typedef logic [7:0] emf_bq_t [$];
  logic mclk, rst_b, tx_valid, tx_last, line_rx_valid, slow;
  logic [7:0] tx_data, line_rx_data, n_sof, n_good, n_err;
  wire logic tx_ready, line_tx_valid, line_tx_ready, rx_valid, rx_sof, rx_good, rx_error;
  wire logic [7:0] line_tx_data, rx_data;
  int n_errors, checks_done, cyc;
  emf_bq_t got;
  emf_framer dut_u (.mclk(mclk), .rst_b(rst_b), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .line_tx_data(line_tx_data),
    .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
    .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_good(rx_good), .rx_error(rx_error));
  emf_line_model line_u (.mclk(mclk), .line_tx_data(line_tx_data),
    .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready), .slow(slow));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cmpq(emf_bq_t a, emf_bq_t b);
    chk(a.size(), b.size());
    foreach (b[i]) if (i < a.size()) chk(a[i], b[i]);
  endtask
  function automatic emf_bq_t with_crc(emf_bq_t m);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (m[i]) for (int b = 7; b >= 0; b--) c = {c[30:0], 1'b0} ^ ((c[31] ^ m[i][b]) ? 32'h04C11DB7 : 32'h0);
    return {m, c[31:24], c[23:16], c[15:8], c[7:0]};
  endfunction
  function automatic emf_bq_t enc(emf_bq_t m);
    emf_bq_t o;
    o = {8'h02};
    foreach (m[i]) begin
      if (m[i] == 8'h02 || m[i] == 8'h03 || m[i] == 8'h1B) o.push_back(8'h1B);
      o.push_back(m[i]);
    end
    o.push_back(8'h03);
    return o;
  endfunction
  task automatic send(emf_bq_t m);
    foreach (m[i]) begin
      tx_data <= m[i];
      tx_valid <= 1'b1;
      tx_last <= (i == m.size() - 1);
      @(posedge mclk);
      while (tx_ready !== 1'b1) @(posedge mclk);
    end
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
  endtask
  task automatic play(emf_bq_t q);
    got.delete();
    {n_sof, n_good, n_err} = 24'h000000;
    foreach (q[i]) begin
      line_rx_data <= q[i];
      line_rx_valid <= 1'b1;
      @(posedge mclk);
    end
    line_rx_valid <= 1'b0;
    line_rx_data <= ~line_rx_data;
    repeat (3) @(posedge mclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_frame(emf_bq_t m, logic s);
    emf_bq_t e;
    e = enc(with_crc(m));
    slow <= s;
    line_u.seen.delete();
    send(m);
    while (line_u.seen.size() < e.size()) @(posedge mclk);
    repeat (6) @(posedge mclk);
    cmpq(line_u.seen, e);
    play(line_u.seen);
    cmpq(got, with_crc(m));
    chk({n_sof, n_good, n_err}, 24'h010100);
  endtask
  task automatic sc_bad();
    emf_bq_t e;
    e = enc(with_crc({8'h10, 8'h20}));
    e[2] = 8'h11;
    play(e);
    chk({n_sof, n_good, n_err}, 24'h010001);
  endtask
  task automatic sc_resync();
    emf_bq_t m;
    m = {8'h02, 8'h77};
    play({8'h55, 8'h1B, 8'h03, 8'h02, 8'h11, 8'h22, enc(with_crc(m))});
    chk({n_sof, n_good, n_err}, 24'h020101);
    cmpq(got, {8'h11, 8'h22, with_crc(m)});
  endtask
  // ****************************************
  // Clock, monitor and main sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) got.push_back(rx_data);
    if (rx_sof === 1'b1) n_sof++;
    if (rx_good === 1'b1) n_good++;
    if (rx_error === 1'b1) n_err++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    {rst_b, tx_valid, tx_last, line_rx_valid, slow} = 5'h00;
    {tx_data, line_rx_data} = 16'h0000;
    {n_errors, checks_done, cyc} = 0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    sc_frame({8'h02, 8'h03, 8'h1B, 8'h41}, 1'b0);
    sc_frame({8'h1B}, 1'b1);
    sc_frame({8'h00, 8'hFF, 8'h5A}, 1'b1);
    sc_bad();
    sc_resync();
    wrap_up();
  end
endmodule
